// File: core/xrs_pkg.sv
// Constants shared by the transceiver reset sequencer and its synchroniser.
// Assumes one reconfiguration-rate clock and user logic that inverts its resets.
//
// Summary of operation
// - Incoming reset requests are synchronised before starting any sequence.
// - Transmit side drives PLL power-down and watches PLL lock.
// - PLL power-down is held eleven cycles (count 0 to ten) when a sequence starts.
// - Transmit side drives analog and digital resets, reads calibration busy, reports ready.
// - Receive side drives analog and digital resets, reads busy and data lock.
// - Integrated-tile variants sequence resets internally; this block is then unused.

`default_nettype none

package xrs_pkg;

	// ---------------------------------------------------------------
	// Timing counts, in cycles of the reconfiguration clock.
	// ---------------------------------------------------------------
	localparam int unsigned XRS_CNT_W         = 4;
	localparam logic [3:0]  XRS_PLL_PD_CYCLES = 4'ha;
	localparam logic [3:0]  XRS_RX_AN_CYCLES  = 4'ha;
	localparam logic [3:0]  XRS_SETTLE_CYCLES = 4'h4;

	// ---------------------------------------------------------------
	// Synchroniser lanes.
	// ---------------------------------------------------------------
	localparam int unsigned XRS_SYNC_W     = 6;
	localparam int unsigned XRS_L_TX_REQ   = 0;
	localparam int unsigned XRS_L_RX_REQ   = 1;
	localparam int unsigned XRS_L_PLL_LOCK = 2;
	localparam int unsigned XRS_L_TX_CAL   = 3;
	localparam int unsigned XRS_L_RX_CAL   = 4;
	localparam int unsigned XRS_L_CDR_LOCK = 5;
	localparam logic [5:0]  XRS_SYNC_RST   = 6'h00;

	// Sequencer states; Gray order along the usual path.
	typedef enum logic [1:0] {
		XRS_S_HOLD   = 2'h0,
		XRS_S_WAIT   = 2'h1,
		XRS_S_SETTLE = 2'h3,
		XRS_S_READY  = 2'h2
	} xrs_state_t;

endpackage

`default_nettype wire

// File: core/xrs_sync_if.sv
// Bundle between the top sequencer and its input synchroniser.
// Assumes both ends share the reconfiguration clock.
`timescale 1ns/10ps
`default_nettype none

interface xrs_sync_if;
	logic [xrs_pkg::XRS_SYNC_W-1:0] raw;
	logic [xrs_pkg::XRS_SYNC_W-1:0] synced;

	modport sink (input raw, output synced);
	modport user (output raw, input synced);
endinterface

`default_nettype wire

// File: core/xrs_sync.sv
// Two-stage synchroniser for every request, lock and busy input of the sequencer.
// Assumes inputs may change at any time relative to the clock.
`timescale 1ns/10ps
`default_nettype none

module xrs_sync (
	input  wire logic  clk,
	input  wire logic  arst_n,
	xrs_sync_if.sink   bus
);

	logic [xrs_pkg::XRS_SYNC_W-1:0] meta_ff;
	logic [xrs_pkg::XRS_SYNC_W-1:0] sync_ff;

	// two-flop sync.
	// The first stage feeds only the second, so a metastable level never fans out.
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			meta_ff <= xrs_pkg::XRS_SYNC_RST;
			sync_ff <= xrs_pkg::XRS_SYNC_RST;
		end else begin
			meta_ff <= bus.raw;
			sync_ff <= meta_ff;
		end
	end

	assign bus.synced = sync_ff;

endmodule // xrs_sync

`default_nettype wire

// File: core/xrs_top.sv
// Transmit and receive transceiver reset sequencers on one reconfiguration clock.
// Assumes the reset requests are already inverted to active high by user logic.
`timescale 1ns/10ps
`default_nettype none

module xrs_top (
	input  wire logic SYS_CLK,
	input  wire logic ARST_N,
	input  wire logic TX_RESET_REQ,
	input  wire logic RX_RESET_REQ,
	input  wire logic TX_PLL_LOCKED,
	input  wire logic TX_CAL_BUSY,
	input  wire logic RX_CAL_BUSY,
	input  wire logic RX_CDR_DATA_LOCK,
	output var  logic TX_PLL_POWERDOWN,
	output var  logic TX_ANALOG_RESET,
	output var  logic TX_DIGITAL_RESET,
	output var  logic TX_READY,
	output var  logic RX_ANALOG_RESET,
	output var  logic RX_DIGITAL_RESET,
	output var  logic RX_READY
);

	// tile variants bypass.
	// Integrated-tile link cores sequence their own resets, so this block is left out there.

	// ---------------------------------------------------------------
	// Input synchronisation.
	// ---------------------------------------------------------------

	xrs_sync_if sbus ();

	logic tx_req;
	logic rx_req;
	logic pll_lock;
	logic tx_cal;
	logic rx_cal;
	logic cdr_lock;

	// requests crossed.
	// Every request, lock and busy pin passes the synchroniser because lock and busy come from other clocks; ARST_N does not.
	assign sbus.raw[xrs_pkg::XRS_L_TX_REQ]   = TX_RESET_REQ;
	assign sbus.raw[xrs_pkg::XRS_L_RX_REQ]   = RX_RESET_REQ;
	assign sbus.raw[xrs_pkg::XRS_L_PLL_LOCK] = TX_PLL_LOCKED;
	assign sbus.raw[xrs_pkg::XRS_L_TX_CAL]   = TX_CAL_BUSY;
	assign sbus.raw[xrs_pkg::XRS_L_RX_CAL]   = RX_CAL_BUSY;
	assign sbus.raw[xrs_pkg::XRS_L_CDR_LOCK] = RX_CDR_DATA_LOCK;

	xrs_sync u_sync (
		.clk    (SYS_CLK),
		.arst_n (ARST_N),
		.bus    (sbus.sink)
	);

	assign tx_req   = sbus.synced[xrs_pkg::XRS_L_TX_REQ];
	assign rx_req   = sbus.synced[xrs_pkg::XRS_L_RX_REQ];
	assign pll_lock = sbus.synced[xrs_pkg::XRS_L_PLL_LOCK];
	assign tx_cal   = sbus.synced[xrs_pkg::XRS_L_TX_CAL];
	assign rx_cal   = sbus.synced[xrs_pkg::XRS_L_RX_CAL];
	assign cdr_lock = sbus.synced[xrs_pkg::XRS_L_CDR_LOCK];

	// ---------------------------------------------------------------
	// Transmit sequencer.
	// ---------------------------------------------------------------

	xrs_pkg::xrs_state_t             tx_state_ff;
	xrs_pkg::xrs_state_t             nxt_tx_state;
	logic [xrs_pkg::XRS_CNT_W-1:0]   tx_cnt_ff;
	logic [xrs_pkg::XRS_CNT_W-1:0]   nxt_tx_cnt;
	logic                            tx_good;

	assign tx_good = pll_lock && !tx_cal;

	// power-down count.
	// A request restarts the whole sequence from any state but hold, where the count runs on, so the PLL is re-powered.
	always_comb begin
		nxt_tx_state = tx_state_ff;
		nxt_tx_cnt   = tx_cnt_ff;
		case (tx_state_ff)
			xrs_pkg::XRS_S_HOLD: begin
				if (tx_cnt_ff != xrs_pkg::XRS_PLL_PD_CYCLES) begin
					nxt_tx_cnt = tx_cnt_ff + 4'h1;
				end else if (!tx_req) begin
					nxt_tx_state = xrs_pkg::XRS_S_WAIT;
					nxt_tx_cnt   = '0;
				end
			end
			xrs_pkg::XRS_S_WAIT: begin
				if (tx_good) begin
					nxt_tx_state = xrs_pkg::XRS_S_SETTLE;
					nxt_tx_cnt   = '0;
				end
			end
			xrs_pkg::XRS_S_SETTLE: begin
				if (!tx_good) begin
					nxt_tx_state = xrs_pkg::XRS_S_WAIT;
				end else if (tx_cnt_ff == xrs_pkg::XRS_SETTLE_CYCLES) begin
					nxt_tx_state = xrs_pkg::XRS_S_READY;
				end else begin
					nxt_tx_cnt = tx_cnt_ff + 4'h1;
				end
			end
			xrs_pkg::XRS_S_READY: begin
				if (!tx_good) begin
					nxt_tx_state = xrs_pkg::XRS_S_WAIT;
				end
			end
			default: begin
				nxt_tx_state = xrs_pkg::XRS_S_HOLD;
				nxt_tx_cnt   = '0;
			end
		endcase
		if (tx_req) begin
			nxt_tx_state = xrs_pkg::XRS_S_HOLD;
			nxt_tx_cnt   = (tx_state_ff == xrs_pkg::XRS_S_HOLD) ? nxt_tx_cnt : '0;
		end
	end

	// Transmit state and counter.
	always_ff @(posedge SYS_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			tx_state_ff <= xrs_pkg::XRS_S_HOLD;
			tx_cnt_ff   <= '0;
		end else begin
			tx_state_ff <= nxt_tx_state;
			tx_cnt_ff   <= nxt_tx_cnt;
		end
	end

	// transmit resets.
	// Outputs are registered from the next state so they move with the state itself.
	always_ff @(posedge SYS_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			TX_PLL_POWERDOWN <= 1'b1;
			TX_ANALOG_RESET  <= 1'b1;
			TX_DIGITAL_RESET <= 1'b1;
			TX_READY         <= 1'b0;
		end else begin
			TX_PLL_POWERDOWN <= (nxt_tx_state == xrs_pkg::XRS_S_HOLD);
			TX_ANALOG_RESET  <= (nxt_tx_state == xrs_pkg::XRS_S_HOLD);
			TX_DIGITAL_RESET <= (nxt_tx_state != xrs_pkg::XRS_S_READY);
			TX_READY         <= (nxt_tx_state == xrs_pkg::XRS_S_READY);
		end
	end

	// ---------------------------------------------------------------
	// Receive sequencer.
	// ---------------------------------------------------------------

	xrs_pkg::xrs_state_t             rx_state_ff;
	xrs_pkg::xrs_state_t             nxt_rx_state;
	logic [xrs_pkg::XRS_CNT_W-1:0]   rx_cnt_ff;
	logic [xrs_pkg::XRS_CNT_W-1:0]   nxt_rx_cnt;
	logic                            rx_good;

	assign rx_good = cdr_lock && !rx_cal;

	// receive sequence.
	// Losing data lock only re-asserts the digital reset; the analog side keeps running.
	always_comb begin
		nxt_rx_state = rx_state_ff;
		nxt_rx_cnt   = rx_cnt_ff;
		case (rx_state_ff)
			xrs_pkg::XRS_S_HOLD: begin
				if (rx_cnt_ff != xrs_pkg::XRS_RX_AN_CYCLES) begin
					nxt_rx_cnt = rx_cnt_ff + 4'h1;
				end else if (!rx_req) begin
					nxt_rx_state = xrs_pkg::XRS_S_WAIT;
					nxt_rx_cnt   = '0;
				end
			end
			xrs_pkg::XRS_S_WAIT: begin
				if (rx_good) begin
					nxt_rx_state = xrs_pkg::XRS_S_SETTLE;
					nxt_rx_cnt   = '0;
				end
			end
			xrs_pkg::XRS_S_SETTLE: begin
				if (!rx_good) begin
					nxt_rx_state = xrs_pkg::XRS_S_WAIT;
				end else if (rx_cnt_ff == xrs_pkg::XRS_SETTLE_CYCLES) begin
					nxt_rx_state = xrs_pkg::XRS_S_READY;
				end else begin
					nxt_rx_cnt = rx_cnt_ff + 4'h1;
				end
			end
			xrs_pkg::XRS_S_READY: begin
				if (!rx_good) begin
					nxt_rx_state = xrs_pkg::XRS_S_WAIT;
				end
			end
			default: begin
				nxt_rx_state = xrs_pkg::XRS_S_HOLD;
				nxt_rx_cnt   = '0;
			end
		endcase
		if (rx_req) begin
			nxt_rx_state = xrs_pkg::XRS_S_HOLD;
			nxt_rx_cnt   = (rx_state_ff == xrs_pkg::XRS_S_HOLD) ? nxt_rx_cnt : '0;
		end
	end

	// Receive state and counter.
	always_ff @(posedge SYS_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			rx_state_ff <= xrs_pkg::XRS_S_HOLD;
			rx_cnt_ff   <= '0;
		end else begin
			rx_state_ff <= nxt_rx_state;
			rx_cnt_ff   <= nxt_rx_cnt;
		end
	end

	always_ff @(posedge SYS_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			RX_ANALOG_RESET  <= 1'b1;
			RX_DIGITAL_RESET <= 1'b1;
			RX_READY         <= 1'b0;
		end else begin
			RX_ANALOG_RESET  <= (nxt_rx_state == xrs_pkg::XRS_S_HOLD);
			RX_DIGITAL_RESET <= (nxt_rx_state != xrs_pkg::XRS_S_READY);
			RX_READY         <= (nxt_rx_state == xrs_pkg::XRS_S_READY);
		end
	end

endmodule // xrs_top

`default_nettype wire

// File: sim/xrs_chk_assertions.sv
// Port-level assertions for the transceiver reset sequencer.
// Assumes it is bound to xrs_top and sees nothing but its ports.
`timescale 1ns/10ps
`default_nettype none

module xrs_chk (
	input wire logic SYS_CLK,
	input wire logic ARST_N,
	input wire logic TX_RESET_REQ,
	input wire logic RX_RESET_REQ,
	input wire logic TX_PLL_LOCKED,
	input wire logic TX_CAL_BUSY,
	input wire logic RX_CAL_BUSY,
	input wire logic RX_CDR_DATA_LOCK,
	input wire logic TX_PLL_POWERDOWN,
	input wire logic TX_ANALOG_RESET,
	input wire logic TX_DIGITAL_RESET,
	input wire logic TX_READY,
	input wire logic RX_ANALOG_RESET,
	input wire logic RX_DIGITAL_RESET,
	input wire logic RX_READY
);
	int pd_run;

	// Counts power-down cycles; a short hold would leave the PLL unsettled.
	always_ff @(posedge SYS_CLK or negedge ARST_N) begin
		if (!ARST_N)
			pd_run <= 0;
		else
			pd_run <= TX_PLL_POWERDOWN ? pd_run + 1 : 0;
	end

	default clocking @(posedge SYS_CLK); endclocking
	default disable iff (!ARST_N);

	// A released analog reset is followed by one wait and five settle cycles.
	sequence tx_quiet6; !TX_READY [*6]; endsequence
	sequence rx_quiet6; !RX_READY [*6]; endsequence

	pd_tracks_a: assert property (TX_PLL_POWERDOWN == TX_ANALOG_RESET)
		else $error("power-down and analog reset differ");
	tx_pair_a: assert property (TX_READY != TX_DIGITAL_RESET)
		else $error("tx ready and digital reset agree");
	rx_pair_a: assert property (RX_READY != RX_DIGITAL_RESET)
		else $error("rx ready and digital reset agree");
	tx_ready_cause_a: assert property (
		TX_READY |-> $past(TX_PLL_LOCKED, 3) && !$past(TX_CAL_BUSY, 3))
		else $error("tx ready without lock");
	rx_ready_cause_a: assert property (
		RX_READY |-> $past(RX_CDR_DATA_LOCK, 3) && !$past(RX_CAL_BUSY, 3))
		else $error("rx ready without lock");
	tx_req_hold_a: assert property (TX_RESET_REQ |-> ##3 TX_PLL_POWERDOWN && !TX_READY)
		else $error("tx request not acted on");
	rx_req_hold_a: assert property (RX_RESET_REQ |-> ##3 RX_ANALOG_RESET && !RX_READY)
		else $error("rx request not acted on");
	pd_hold_a: assert property ($fell(TX_PLL_POWERDOWN) |-> pd_run >= 11)
		else $error("power-down held too briefly");
	tx_settle_a: assert property ($fell(TX_ANALOG_RESET) |-> tx_quiet6)
		else $error("tx ready too early");
	rx_settle_a: assert property ($fell(RX_ANALOG_RESET) |-> rx_quiet6)
		else $error("rx ready too early");
endmodule // xrs_chk

bind xrs_top xrs_chk u_chk (.*);

`default_nettype wire

// File: sim/xrs_phy_model.sv
// Behavioural transceiver channel and transmit PLL facing the sequencer.
// Assumes the bench drives the lock delay and the lock-loss control.
`timescale 1ns/10ps
`default_nettype none

module xrs_phy_model (
	input  wire logic       clk,
	input  wire logic       pd,
	input  wire logic       tx_an,
	input  wire logic       rx_an,
	input  wire logic       drop,
	input  wire logic [3:0] dly,
	output logic            pll_lock,
	output logic            tx_cal,
	output logic            rx_cal,
	output logic            cdr_lock
);
	int ct = 0;
	int cr = 0;

	// Cycles since PLL power-up and since the receiver analog release.
	always @(posedge clk) begin
		ct <= pd ? 0 : ct + 1;
		cr <= rx_an ? 0 : cr + 1;
	end

	// Locks come late by a variable wait and vanish at once when lost.
	// A drop with an odd delay raises calibration busy instead, so ready also sees busy alone.
	assign pll_lock = !pd && !(drop && !dly[0]) && ct > dly;
	assign cdr_lock = !rx_an && !(drop && !dly[0]) && cr > dly;
	// Calibration stays busy through analog reset and a short tail.
	assign tx_cal = tx_an || ct < 3 || (drop && dly[0]);
	assign rx_cal = rx_an || cr < 2 || (drop && dly[0]);
endmodule // xrs_phy_model

`default_nettype wire

// File: sim/tb_top.sv
// Self-checking bench: cycle model of both sequencers compared every cycle.
// Assumes a 200 MHz clock and user resets that are active low.
`timescale 1ns/10ps
`default_nettype none

module tb_top;
	logic       clk = 0;
	logic       arst_n, tx_rst_n, rx_rst_n, drop;
	logic [3:0] dly;
	logic       pll_lock, tx_cal, rx_cal, cdr_lock;
	logic       pd, tx_an, tx_dig, tx_rdy, rx_an, rx_dig, rx_rdy;
	logic [1:0] r1, r2, g1, g2;
	int         failures = 0, n_checks = 0, seed = 19, st[2], cnt[2];

	// one clock source.
	// One generator feeds both sequencers, standing in for the shared reconfiguration clock.
	initial forever #2.5 clk = ~clk;

	// reconfiguration buses stay outside this block, so nothing here drives them.
	xrs_top DUT (.SYS_CLK(clk), .ARST_N(arst_n),
		.TX_RESET_REQ(!tx_rst_n), .RX_RESET_REQ(!rx_rst_n),
		.TX_PLL_LOCKED(pll_lock), .TX_CAL_BUSY(tx_cal), .RX_CAL_BUSY(rx_cal),
		.RX_CDR_DATA_LOCK(cdr_lock), .TX_PLL_POWERDOWN(pd), .TX_ANALOG_RESET(tx_an),
		.TX_DIGITAL_RESET(tx_dig), .TX_READY(tx_rdy), .RX_ANALOG_RESET(rx_an),
		.RX_DIGITAL_RESET(rx_dig), .RX_READY(rx_rdy));
	xrs_phy_model PHY (.clk(clk), .pd(pd), .tx_an(tx_an), .rx_an(rx_an),
		.drop(drop), .dly(dly),
		.pll_lock(pll_lock), .tx_cal(tx_cal), .rx_cal(rx_cal), .cdr_lock(cdr_lock));

	task automatic chk(input string name, input logic exp, input logic got);
		n_checks++;
		if (got !== exp) begin
			failures++;
			$display("unexpected %s: expected %b, seen %b", name, exp, got);
		end
	endtask

	// One sequencer step: states hold, wait, settle, ready as 0 to 3.
	task automatic step(input int i, input logic r, input logic g);
		int hold_n;
		hold_n = i ? int'(xrs_pkg::XRS_RX_AN_CYCLES) : int'(xrs_pkg::XRS_PLL_PD_CYCLES);
		if (r) begin
			if (st[i] != 0) cnt[i] = 0;
			else if (cnt[i] < hold_n) cnt[i]++;
			st[i] = 0;
		end else case (st[i])
			0: if (cnt[i] == hold_n) st[i] = 1; else cnt[i]++;
			1: if (g) begin st[i] = 2; cnt[i] = 0; end
			2: if (!g) st[i] = 1;
				else if (cnt[i] == int'(xrs_pkg::XRS_SETTLE_CYCLES)) st[i] = 3;
				else cnt[i]++;
			3: if (!g) st[i] = 1;
		endcase
	endtask

	// Model with its own two-stage input pipeline, as the synchroniser adds.
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			st = '{0, 0}; cnt = '{0, 0}; r1 = 0; r2 = 0; g1 = 0; g2 = 0;
		end else begin
			step(0, r2[0], g2[0]);
			step(1, r2[1], g2[1]);
			r2 = r1; g2 = g1;
			r1 = {!rx_rst_n, !tx_rst_n};
			g1 = {cdr_lock && !rx_cal, pll_lock && !tx_cal};
		end
	end

	// Outputs are settled by the falling edge.
	always @(negedge clk) begin
		if (arst_n) begin
			chk("pll power-down", st[0] == 0, pd);
			chk("tx analog reset", st[0] == 0, tx_an);
			chk("tx digital reset", st[0] != 3, tx_dig);
			chk("tx ready", st[0] == 3, tx_rdy);
			chk("rx analog reset", st[1] == 0, rx_an);
			chk("rx digital reset", st[1] != 3, rx_dig);
			chk("rx ready", st[1] == 3, rx_rdy);
		end
	end

	task automatic run(input int n, input logic t, input logic r, input logic d);
		@(negedge clk);
		tx_rst_n <= t;
		rx_rst_n <= r;
		drop <= d;
		dly <= 4'($random(seed));
		repeat (n - 1) @(negedge clk);
	endtask

	task report_and_stop;
		$display("checks %0d, mismatches %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask

	// Bring-up, requests in ready and in hold, lock loss, reset mid-run, then random.
	initial begin
		arst_n = 0; tx_rst_n = 1; rx_rst_n = 1; drop = 0; dly = 4'h3;
		repeat (6) @(negedge clk);
		arst_n <= 1;
		run(40, 1, 1, 0);
		run(3, 0, 0, 0);
		run(40, 1, 1, 0);
		run(4, 1, 1, 1);
		run(30, 1, 1, 0);
		run(2, 0, 1, 0);
		run(5, 1, 1, 0);
		run(2, 0, 1, 0);
		run(9, 1, 1, 0);
		arst_n <= 0;
		run(3, 1, 1, 0);
		arst_n <= 1;
		repeat (60) run((($random(seed)) & 31) + 1, ($random(seed) & 7) != 0,
			($random(seed) & 7) != 0, ($random(seed) & 3) == 0);
		report_and_stop;
	end

	// Watchdog well beyond the roughly 1130 cycles expected and the 2064 at most.
	initial begin
		#50000;
		failures++;
		report_and_stop;
	end
endmodule // tb_top

`default_nettype wire
